// ### verilog/ebi_pkg.sv
package ebi_pkg;
  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [15:0] INT_TOP = 16'h21FF;
  // ----------------------------------------------------------------
  // Wait-state and high-mask encodings, pin reset value and sequencer states
  // ----------------------------------------------------------------
  localparam int WAIT_W = 2;
  localparam int MASK_W = 3;
  localparam logic [7:0] PIN_RST = 8'h00;
  localparam logic [2:0] MASK_NONE = 3'h0;
  localparam logic [2:0] MASK_MAX = 3'h7;
  typedef enum logic [2:0] {EBI_IDLE, EBI_ADDR, EBI_XFER, EBI_WAIT, EBI_TAIL} ebi_state_type;
endpackage : ebi_pkg

// ### verilog/ebi_top.sv
// Behaviour
// - While enabled the interface owns its dedicated pins regardless of port direction settings.
// - Each data-space access is classed internal or external by address and external ones drive the bus.
// - The low address byte is on the shared bus and stable when the latch strobe falls.
// - The latch strobe stays low through the whole data transfer phase.
// - Internal accesses may move address, data and latch strobe but never read or write strobes.
// - When disabled the dedicated pins act as ordinary ports.
// - When disabled addresses above internal memory never alias onto internal SRAM.
// - The high address byte goes out on its own bus with a software-chosen number of active bits.
// - While enabled, shared low bus pull-ups are on where the port output register bits are one.
// - An enabled bus keeper holds the last driven value whenever the enabled interface releases the shared bus.
// - Four wait-state settings, including zero, stretch external cycles.
// - Upper and lower sectors each carry their own two-bit wait setting.
// - The trailing latch pulse comes after the access, one period later per wait step, only if RAM follows.
// - Addresses up to 0x21FF always stay internal.
// - With high mask bits at zero the full unmodified address is driven on the bus.
// - High mask bits hand the top address pins back to their port output values.
module ebi_top #(
  parameter logic [15:0] SECTOR_LIMIT_DEFAULT = 16'h0000
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic ext_bus_enable_i,
  input wire logic keeper_enable_i,
  input wire logic [2:0] high_addr_mask_bits_i,
  input wire logic [15:0] sector_limit_i,
  input wire logic upper_sector_wait_hi_i,
  input wire logic upper_sector_wait_lo_i,
  input wire logic lower_sector_wait_hi_i,
  input wire logic lower_sector_wait_lo_i,
  input wire logic acc_req_i,
  input wire logic acc_write_i,
  input wire logic [15:0] acc_addr_i,
  input wire logic [7:0] acc_wdata_i,
  input wire logic next_ram_i,
  input wire logic [7:0] port_low_out_i,
  input wire logic [7:0] port_low_dir_i,
  input wire logic [7:0] port_high_out_i,
  input wire logic [7:0] port_high_dir_i,
  input wire logic port_ctrl_out_i,
  input wire logic [2:0] port_ctrl_dir_i,
  input wire logic [7:0] shared_addr_data_low_i,
  output logic [7:0] shared_addr_data_low_o,
  output logic [7:0] shared_addr_data_low_oe_n_o,
  output logic [7:0] shared_addr_data_low_pullup_o,
  output logic [7:0] high_addr_bus_o,
  output logic [7:0] high_addr_bus_oe_n_o,
  output logic latch_strobe_o,
  output logic read_strobe_n_o,
  output logic write_strobe_n_o,
  output logic [2:0] ctrl_oe_n_o,
  output logic acc_external_o,
  output logic acc_done_o,
  output logic [7:0] acc_rdata_o
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  // Asynchronous assert, synchronous release
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta <= ebi_pkg::PIN_RST;
      pin_sync <= ebi_pkg::PIN_RST;
    end
    else
    begin
      pin_meta <= shared_addr_data_low_i;
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Anything at or below the internal top is classed internal and never raises a read or write strobe
  function automatic logic ebi_is_ext(input logic [15:0] a);
    ebi_is_ext = (a > ebi_pkg::INT_TOP);
  endfunction : ebi_is_ext

  // Nonzero mask value n releases the n+1 top pins, 1 means two pins
  function automatic logic [7:0] ebi_mask_of(input logic [2:0] m);
    logic [7:0] k;
    k = 8'hFF;
    if (m != ebi_pkg::MASK_NONE)
    begin
      k = 8'hFF >> (4'd1 + {1'b0, m});
    end
    ebi_mask_of = k;
  endfunction : ebi_mask_of

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  ebi_pkg::ebi_state_type state;
  logic [1:0] wait_left;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic is_write;
  logic is_ext;
  logic tail_pulse;
  logic [7:0] keep_val;
  logic bus_driving;
  logic [1:0] sel_wait;
  logic start_ok;

  // Sector split: at or above a non-default limit is upper sector
  always_comb
  begin
    if (acc_addr_i >= sector_limit_i && sector_limit_i != SECTOR_LIMIT_DEFAULT)
    begin
      sel_wait = {upper_sector_wait_hi_i, upper_sector_wait_lo_i};
    end
    else
    begin
      sel_wait = {lower_sector_wait_hi_i, lower_sector_wait_lo_i};
    end
  end

  // Accesses are only taken with the bus enabled; a disabled bus never
  // falls through to internal memory for high addresses
  assign start_ok = acc_req_i && ext_bus_enable_i
                    && (state == ebi_pkg::EBI_IDLE || state == ebi_pkg::EBI_TAIL);

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ebi_pkg::EBI_IDLE;
      wait_left <= 2'h0;
      addr <= 16'h0000;
      wdata <= 8'h00;
      is_write <= 1'b0;
      is_ext <= 1'b0;
    end
    else
    begin
      case (state)
        ebi_pkg::EBI_IDLE, ebi_pkg::EBI_TAIL:
        begin
          if (start_ok)
          begin
            state <= ebi_pkg::EBI_ADDR;
            addr <= acc_addr_i;
            wdata <= acc_wdata_i;
            is_write <= acc_write_i;
            is_ext <= ebi_is_ext(acc_addr_i);
            wait_left <= sel_wait;
          end
          else
          begin
            state <= ebi_pkg::EBI_IDLE;
          end
        end
        ebi_pkg::EBI_ADDR:
        begin
          state <= ebi_pkg::EBI_XFER;
        end
        ebi_pkg::EBI_XFER, ebi_pkg::EBI_WAIT:
        begin
          if (wait_left != 2'h0)
          begin
            wait_left <= wait_left - 2'h1;
            state <= ebi_pkg::EBI_WAIT;
          end
          else
          begin
            state <= ebi_pkg::EBI_TAIL;
          end
        end
        default:
        begin
          state <= ebi_pkg::EBI_IDLE;
        end
      endcase
    end
  end

  // Trailing latch pulse only when the next instruction touches RAM
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tail_pulse <= 1'b0;
    end
    else
    begin
      tail_pulse <= (state == ebi_pkg::EBI_XFER || state == ebi_pkg::EBI_WAIT) && wait_left == 2'h0
                    && next_ram_i;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  logic [7:0] hmask;
  assign hmask = ebi_mask_of(high_addr_mask_bits_i);
  assign bus_driving = state == ebi_pkg::EBI_ADDR || (is_write && (state == ebi_pkg::EBI_XFER
                       || state == ebi_pkg::EBI_WAIT));

  // Remember what we last put on the shared bus for the keeper
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      keep_val <= 8'h00;
    end
    else if (bus_driving)
    begin
      keep_val <= (state == ebi_pkg::EBI_ADDR) ? addr[7:0] : wdata;
    end
  end

  // All pins registered; disabled bus hands everything to the ports
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shared_addr_data_low_o <= 8'h00;
      shared_addr_data_low_oe_n_o <= 8'hFF;
      shared_addr_data_low_pullup_o <= 8'h00;
      high_addr_bus_o <= 8'h00;
      high_addr_bus_oe_n_o <= 8'hFF;
      latch_strobe_o <= 1'b0;
      read_strobe_n_o <= 1'b1;
      write_strobe_n_o <= 1'b1;
      ctrl_oe_n_o <= 3'h7;
    end
    else if (!ext_bus_enable_i)
    begin
      shared_addr_data_low_o <= port_low_out_i;
      shared_addr_data_low_oe_n_o <= ~port_low_dir_i;
      shared_addr_data_low_pullup_o <= port_low_out_i & ~port_low_dir_i;
      high_addr_bus_o <= port_high_out_i;
      high_addr_bus_oe_n_o <= ~port_high_dir_i;
      latch_strobe_o <= port_ctrl_out_i;
      read_strobe_n_o <= port_ctrl_out_i;
      write_strobe_n_o <= port_ctrl_out_i;
      ctrl_oe_n_o <= ~port_ctrl_dir_i;
    end
    else
    begin
      ctrl_oe_n_o <= 3'h0;
      // Strobe rises as the low address is launched and falls a cycle later,
      // so the address is settled on the pins before the latch closes
      latch_strobe_o <= start_ok || (tail_pulse && !start_ok);
      if (start_ok)
      begin
        shared_addr_data_low_o <= acc_addr_i[7:0];
        shared_addr_data_low_oe_n_o <= 8'h00;
      end
      else if (state == ebi_pkg::EBI_ADDR)
      begin
        shared_addr_data_low_o <= addr[7:0];
        shared_addr_data_low_oe_n_o <= 8'h00;
      end
      else if (bus_driving)
      begin
        shared_addr_data_low_o <= wdata;
        shared_addr_data_low_oe_n_o <= 8'h00;
      end
      else
      begin
        // Released: keeper holds last value, else pull-ups decide
        shared_addr_data_low_o <= keeper_enable_i ? keep_val : 8'h00;
        shared_addr_data_low_oe_n_o <= keeper_enable_i ? 8'h00 : 8'hFF;
      end
      shared_addr_data_low_pullup_o <= port_low_out_i;
      high_addr_bus_o <= (addr[15:8] & hmask) | (port_high_out_i & ~hmask);
      high_addr_bus_oe_n_o <= ~(hmask | port_high_dir_i);
      // Strobes cover only the data phase, never the address phase
      read_strobe_n_o <= !(is_ext && !is_write && (state == ebi_pkg::EBI_XFER
                         || state == ebi_pkg::EBI_WAIT));
      write_strobe_n_o <= !(is_ext && is_write && (state == ebi_pkg::EBI_XFER
                          || state == ebi_pkg::EBI_WAIT));
    end
  end

  // ----------------------------------------------------------------
  // Request side results
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_done_o <= 1'b0;
      acc_external_o <= 1'b0;
      acc_rdata_o <= 8'h00;
    end
    else
    begin
      acc_done_o <= (state == ebi_pkg::EBI_XFER || state == ebi_pkg::EBI_WAIT) && wait_left == 2'h0;
      acc_external_o <= is_ext;
      if ((state == ebi_pkg::EBI_XFER || state == ebi_pkg::EBI_WAIT) && wait_left == 2'h0 && !is_write)
      begin
        acc_rdata_o <= pin_sync;
      end
    end
  end
endmodule : ebi_top

// ### tb/ebi_top_monitor.sv
module ebi_top_monitor (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic ext_bus_enable_i,
  input wire logic [2:0] high_addr_mask_bits_i,
  input wire logic [15:0] sector_limit_i,
  input wire logic upper_sector_wait_hi_i,
  input wire logic upper_sector_wait_lo_i,
  input wire logic lower_sector_wait_hi_i,
  input wire logic lower_sector_wait_lo_i,
  input wire logic acc_req_i,
  input wire logic [15:0] acc_addr_i,
  input wire logic [7:0] port_low_out_i,
  input wire logic [7:0] port_low_dir_i,
  input wire logic [7:0] port_high_out_i,
  input wire logic [7:0] shared_addr_data_low_o,
  input wire logic [7:0] shared_addr_data_low_oe_n_o,
  input wire logic [7:0] shared_addr_data_low_pullup_o,
  input wire logic [7:0] high_addr_bus_o,
  input wire logic [7:0] high_addr_bus_oe_n_o,
  input wire logic latch_strobe_o,
  input wire logic read_strobe_n_o,
  input wire logic write_strobe_n_o,
  input wire logic acc_external_o,
  input wire logic acc_done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------
  // Helper state
  // ----------------
  logic [15:0] addr_q;
  logic [1:0] wait_q;
  logic [3:0] low_cnt;
  logic [3:0] cyc_q;
  wire logic idle_w = read_strobe_n_o & write_strobe_n_o;

  // Address and sector wait captured at the taking edge
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      addr_q <= 16'h0000;
      wait_q <= 2'h0;
    end
    else if (acc_req_i && ext_bus_enable_i)
    begin
      addr_q <= acc_addr_i;
      wait_q <= (sector_limit_i != 16'h0000 && acc_addr_i >= sector_limit_i) ?
        {upper_sector_wait_hi_i, upper_sector_wait_lo_i} : {lower_sector_wait_hi_i, lower_sector_wait_lo_i};
    end
  end

  // Strobe length and latency counters; only the latency counter saturates, the strobe length counter can wrap
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      low_cnt <= 4'h0;
      cyc_q <= 4'h0;
    end
    else
    begin
      low_cnt <= idle_w ? 4'h0 : low_cnt + 4'h1;
      cyc_q <= acc_req_i ? 4'h1 : (cyc_q == 4'hF ? cyc_q : cyc_q + 4'h1);
    end
  end

  // ----------------
  // Assertions
  // ----------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  int_quiet_a:
    assert property (acc_req_i && acc_addr_i <= ebi_pkg::INT_TOP |=> idle_w [*6]) else $error("strobe on internal");
  off_quiet_a:
    assert property (!ext_bus_enable_i && $past(!ext_bus_enable_i) |-> idle_w) else $error("strobe while off");
  port_dir_a:
    assert property (!ext_bus_enable_i && $past(!ext_bus_enable_i) && $stable(port_low_dir_i)
      |-> shared_addr_data_low_oe_n_o == ~port_low_dir_i) else $error("low port direction");
  pull_up_a:
    assert property (ext_bus_enable_i && $stable(port_low_out_i) && shared_addr_data_low_oe_n_o == 8'hFF
      |-> shared_addr_data_low_pullup_o == port_low_out_i) else $error("pull-up mismatch");
  addr_latch_a:
    assert property (acc_req_i && ext_bus_enable_i |=> latch_strobe_o && shared_addr_data_low_o == addr_q[7:0]
      ##1 (!latch_strobe_o && shared_addr_data_low_oe_n_o == 8'h00 && shared_addr_data_low_o == addr_q[7:0]))
      else $error("low address");
  latch_low_a:
    assert property (!idle_w |-> !latch_strobe_o) else $error("latch high in transfer");
  strobe_len_a:
    assert property ($rose(idle_w) |-> low_cnt == {2'h0, wait_q} + 4'h1) else $error("strobe length");
  done_time_a:
    assert property (acc_done_o && acc_external_o |-> cyc_q == {2'h0, wait_q} + 4'h3) else $error("done latency");
  full_addr_a:
    assert property (!idle_w && high_addr_mask_bits_i == 3'h0 |-> high_addr_bus_oe_n_o == 8'h00
      && high_addr_bus_o == addr_q[15:8]) else $error("high address");
  mask_rel_a:
    assert property (!idle_w && high_addr_mask_bits_i == 3'h1 |-> high_addr_bus_o == {port_high_out_i[7:6],
      addr_q[13:8]}) else $error("masked pins");
  cover property ($rose(idle_w) && wait_q == 2'h3);
  cover property (acc_done_o && !acc_external_o);
  cover property (!idle_w && high_addr_mask_bits_i == 3'h1);
endmodule : ebi_top_monitor

bind ebi_top ebi_top_monitor i_mon (.*);

// ### tb/ebi_sram_model.sv
module ebi_sram_model (
  input wire logic clk_i,
  input wire logic latch_strobe_i,
  input wire logic [7:0] pin_i,
  input wire logic [7:0] high_i,
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  output logic drive_o,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] low_q;
  logic [7:0] mem [0:65535];

  // Transparent latch; holds what stood on the bus at the falling strobe
  always_latch
  begin
    if (latch_strobe_i)
      low_q <= pin_i;
  end

  // Full 16-bit decode so aliasing would show up as a miss
  always @(posedge clk_i)
  begin
    if (!write_strobe_n_i)
      mem[{high_i, low_q}] <= pin_i;
  end
  assign drive_o = !read_strobe_n_i;
  assign data_o = mem[{high_i, low_q}];
endmodule : ebi_sram_model

// ### tb/tb_ebi_top.sv
module tb_ebi_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 1'b0, reset_n_i = 1'b0, ext_bus_enable_i = 1'b0, keeper_enable_i = 1'b0;
  // Control port parked high so read and write strobe pins read inactive while the bus is off
  logic acc_req_i = 1'b0, acc_write_i = 1'b0, next_ram_i = 1'b0, port_ctrl_out_i = 1'b1;
  logic upper_sector_wait_hi_i = 1'b0, upper_sector_wait_lo_i = 1'b0;
  logic lower_sector_wait_hi_i = 1'b0, lower_sector_wait_lo_i = 1'b0;
  logic [2:0] high_addr_mask_bits_i = 3'h0, port_ctrl_dir_i = 3'h0, ctrl_oe_n_o;
  logic [15:0] sector_limit_i = 16'h0000, acc_addr_i = 16'h0000;
  logic [7:0] acc_wdata_i = 8'h00, port_low_out_i = 8'h00, port_low_dir_i = 8'h00;
  logic [7:0] port_high_out_i = 8'h00, port_high_dir_i = 8'h00, acc_rdata_o, mem_data;
  logic [7:0] shared_addr_data_low_o, shared_addr_data_low_oe_n_o, shared_addr_data_low_pullup_o;
  logic [7:0] high_addr_bus_o, high_addr_bus_oe_n_o;
  logic latch_strobe_o, read_strobe_n_o, write_strobe_n_o, acc_external_o, acc_done_o, mem_drive;
  wire logic [7:0] shared_addr_data_low_i;
  int bad_count = 0, tests_run = 0, lat;

  // Released lines show the inverse so a stale value never passes
  assign shared_addr_data_low_i = mem_drive ? mem_data : shared_addr_data_low_o ^ shared_addr_data_low_oe_n_o;
  always #5 core_clk_i = ~core_clk_i;
  ebi_top i_dut (.*);
  ebi_sram_model i_mem (.clk_i(core_clk_i), .latch_strobe_i(latch_strobe_o), .pin_i(shared_addr_data_low_i),
    .high_i(high_addr_bus_o), .read_strobe_n_i(read_strobe_n_o), .write_strobe_n_i(write_strobe_n_o),
    .drive_o(mem_drive), .data_o(mem_data));

  // ----------------
  // Tasks
  // ----------------
  task automatic wrap_up;
    $display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic waits(input logic [1:0] lo, input logic [1:0] up);
    {lower_sector_wait_hi_i, lower_sector_wait_lo_i} = lo;
    {upper_sector_wait_hi_i, upper_sector_wait_lo_i} = up;
  endtask : waits

  // One-cycle request, then count edges until done; lat ends as latency
  task automatic access(input logic wr, input logic [15:0] addr, input logic [7:0] data);
    acc_write_i = wr;
    acc_addr_i = addr;
    acc_wdata_i = data;
    acc_req_i = 1'b1;
    @(posedge core_clk_i) #1;
    acc_req_i = 1'b0;
    for (lat = 1; lat < 20 && acc_done_o !== 1'b1; lat++)
      @(posedge core_clk_i) #1;
    if (lat == 20)
    begin
      bad_count++;
      wrap_up();
    end
    @(posedge core_clk_i) #1;
  endtask : access

  // ----------------
  // Main sequence
  // ----------------
  initial
  begin
    repeat (12) @(posedge core_clk_i);
    #1 reset_n_i = 1'b1;
    repeat (3) @(posedge core_clk_i);
    #1 check(shared_addr_data_low_oe_n_o, 8'hFF);
    check({3'h0, ctrl_oe_n_o, read_strobe_n_o, write_strobe_n_o}, 8'h1F);
    port_low_dir_i = 8'hA5;
    repeat (2) @(posedge core_clk_i) #1;
    check(shared_addr_data_low_oe_n_o, 8'h5A);
    {ext_bus_enable_i, keeper_enable_i, next_ram_i, port_low_out_i} = {3'h7, 8'h3C};
    repeat (3) @(posedge core_clk_i) #1;
    check(shared_addr_data_low_pullup_o, 8'h3C);
    check({5'h00, ctrl_oe_n_o}, 8'h00);
    for (int w = 0; w < 4; w++)
    begin
      waits(2'(w), 2'h0);
      access(1'b1, 16'h2200 + 16'(w), 8'h10 + 8'(w));
      check(8'(lat), 8'(3 + w));
      check(shared_addr_data_low_o, 8'h10 + 8'(w));
      check({7'h00, latch_strobe_o}, 8'h01);
    end
    for (int w = 0; w < 4; w++)
    begin
      access(1'b0, 16'h2200 + 16'(w), 8'h00);
      check(acc_rdata_o, 8'h10 + 8'(w));
    end
    access(1'b1, 16'h21FF, 8'hEE);
    check({7'h00, acc_external_o}, 8'h00);
    sector_limit_i = 16'h8000;
    waits(2'h1, 2'h2);
    access(1'b1, 16'h8000, 8'h77);
    check(8'(lat), 8'h05);
    next_ram_i = 1'b0;
    access(1'b1, 16'h2300, 8'h66);
    check(8'(lat), 8'h04);
    check({7'h00, latch_strobe_o}, 8'h00);
    next_ram_i = 1'b1;
    waits(2'h3, 2'h3);
    access(1'b0, 16'h8000, 8'h00);
    check(acc_rdata_o, 8'h77);
    check(high_addr_bus_o, 8'h80);
    {port_high_dir_i, high_addr_mask_bits_i} = {8'hFF, 3'h1};
    access(1'b1, 16'h4001, 8'hAA);
    high_addr_mask_bits_i = 3'h0;
    access(1'b1, 16'h4001, 8'h55);
    high_addr_mask_bits_i = 3'h1;
    access(1'b0, 16'h4001, 8'h00);
    check(acc_rdata_o, 8'hAA);
    high_addr_mask_bits_i = 3'h0;
    access(1'b0, 16'h4001, 8'h00);
    check(acc_rdata_o, 8'h55);
    {ext_bus_enable_i, acc_addr_i, acc_req_i, lat} = {1'b0, 16'h3000, 1'b1, 32'd0};
    repeat (8)
    begin
      @(posedge core_clk_i) #1;
      acc_req_i = 1'b0;
      if (acc_done_o !== 1'b0)
        lat++;
    end
    check(8'(lat), 8'h00);
    wrap_up();
  end
endmodule : tb_ebi_top
